// [design/xcr_pkg.sv]
// Constants, types and register map of the transceiver configuration bank
package xcr_pkg;

   // ------------------------------------------------------------
   // Bus and map geometry
   // ------------------------------------------------------------
   localparam int          ADDR_LSB   = 2;
   localparam int          IDX_W      = 7;
   localparam int          FIFO_DEPTH = 64;
   localparam int          FIFO_AW    = 6;
   localparam int          FIFO_CW    = 7;
   localparam logic [6:0]  FIFO_FULL_CNT  = 7'h40;
   localparam logic [6:0]  FIFO_LEVEL_CNT = 7'h20;
   localparam int          IRQ_W      = 5;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [6:0] IDX_FIFO     = 7'h00;
   localparam logic [6:0] IDX_OPMODE   = 7'h01;
   localparam logic [6:0] IDX_RATE_HI  = 7'h02;
   localparam logic [6:0] IDX_RATE_LO  = 7'h03;
   localparam logic [6:0] IDX_DEV_HI   = 7'h04;
   localparam logic [6:0] IDX_DEV_LO   = 7'h05;
   localparam logic [6:0] IDX_TIMER1   = 7'h39;
   localparam logic [6:0] IDX_TIMER2   = 7'h3A;
   localparam logic [6:0] IDX_IMGCAL   = 7'h3B;
   localparam logic [6:0] IDX_TEMP     = 7'h3C;
   localparam logic [6:0] IDX_LOWBAT   = 7'h3D;
   localparam logic [6:0] IDX_FLAGS1   = 7'h3E;
   localparam logic [6:0] IDX_FLAGS2   = 7'h3F;
   localparam logic [6:0] IDX_MAP1     = 7'h40;
   localparam logic [6:0] IDX_MAP2     = 7'h41;
   localparam logic [6:0] IDX_VERSION  = 7'h42;
   localparam logic [6:0] IDX_HOP      = 7'h44;
   localparam logic [6:0] IDX_REFSEL   = 7'h4B;
   localparam logic [6:0] IDX_PAHI     = 7'h4D;
   localparam logic [6:0] IDX_CALTEMP  = 7'h5B;
   localparam logic [6:0] IDX_FRAC     = 7'h5D;
   localparam logic [6:0] IDX_AGC_REF  = 7'h61;
   localparam logic [6:0] IDX_AGC_TH1  = 7'h62;
   localparam logic [6:0] IDX_AGC_TH2  = 7'h63;
   localparam logic [6:0] IDX_AGC_TH3  = 7'h64;
   localparam logic [6:0] IDX_PLL      = 7'h70;
   localparam logic [6:0] IDX_IRQ_STAT = 7'h78;
   localparam logic [6:0] IDX_IRQ_CLR  = 7'h79;
   localparam logic [6:0] IDX_IRQ_EN   = 7'h7A;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_OPMODE  = 8'h09;
   localparam logic [7:0] RST_RATE_HI = 8'h1A;
   localparam logic [7:0] RST_RATE_LO = 8'h0B;
   localparam logic [7:0] RST_DEV_HI  = 8'h00;
   localparam logic [7:0] RST_DEV_LO  = 8'h52;
   localparam logic [7:0] RST_TIMER1  = 8'hF5;
   localparam logic [7:0] RST_TIMER2  = 8'h20;
   localparam logic [7:0] RST_IMGCAL  = 8'h82;
   localparam logic [7:0] RST_LOWBAT  = 8'h02;
   localparam logic [7:0] RST_FLAGS1  = 8'h80;
   localparam logic [7:0] RST_MAP     = 8'h00;
   localparam logic [7:0] RST_HOP     = 8'h2D;
   localparam logic [7:0] RST_REFSEL  = 8'h09;
   localparam logic [7:0] RST_PAHI    = 8'h84;
   localparam logic [7:0] RST_FRAC    = 8'h00;
   localparam logic [7:0] RST_AGC_REF = 8'h13;
   localparam logic [7:0] RST_AGC_TH1 = 8'h0E;
   localparam logic [7:0] RST_AGC_TH2 = 8'h5B;
   localparam logic [7:0] RST_AGC_TH3 = 8'hDB;
   localparam logic [7:0] RST_PLL     = 8'hD0;
   localparam logic [7:0] RST_ZERO    = 8'h00;
   // Arbitrary neutral revision code
   localparam logic [7:0] REVISION_CODE = 8'h5A;

   // ------------------------------------------------------------
   // Field positions and masks
   // ------------------------------------------------------------
   localparam logic [7:0] DEV_HI_MASK     = 8'h3F;
   localparam logic [7:0] IMGCAL_MASK     = 8'hBF;
   localparam int         IMGCAL_START    = 6;
   localparam int         FRAC_W          = 4;
   localparam int         F2_FULL         = 7;
   localparam int         F2_EMPTY        = 6;
   localparam int         F2_LEVEL        = 5;
   localparam int         F2_OVERRUN      = 4;
   localparam int         F2_LOWBAT       = 0;
   localparam int         EV_OVERRUN      = 0;
   localparam int         EV_UNDERRUN     = 1;
   localparam int         EV_FAMILY_REJ   = 2;
   localparam int         EV_BAD_WRITE    = 3;
   localparam int         EV_LOWBAT       = 4;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      XCR_SLEEP   = 3'b000,
      XCR_STANDBY = 3'b001,
      XCR_SYN_TX  = 3'b010,
      XCR_TX      = 3'b011,
      XCR_SYN_RX  = 3'b100,
      XCR_RX      = 3'b101,
      XCR_RSV6    = 3'b110,
      XCR_RSV7    = 3'b111
   } xcr_mode_t;

   typedef enum logic [1:0] {
      XCR_FSK  = 2'b00,
      XCR_OOK  = 2'b01,
      XCR_MRS2 = 2'b10,
      XCR_MRS3 = 2'b11
   } xcr_mod_t;

   typedef enum logic {
      XCR_PH_IDLE   = 1'b0,
      XCR_PH_ANSWER = 1'b1
   } xcr_phase_t;

   typedef struct packed {
      logic      modem_family_select;
      xcr_mod_t  modulation_scheme;
      logic      rsv;
      logic      low_band_bank_select;
      xcr_mode_t mode;
   } xcr_opmode_t;

   typedef struct packed {
      logic [7:0] ref_level;
      logic [7:0] thresh1;
      logic [7:0] thresh2;
      logic [7:0] thresh3;
      logic [7:0] pll_bw;
   } xcr_bank_t;

   typedef struct packed {
      xcr_opmode_t          opmode;
      logic [7:0]           rate_hi;
      logic [7:0]           rate_lo;
      logic [7:0]           dev_hi;
      logic [7:0]           dev_lo;
      logic [7:0]           timer1;
      logic [7:0]           timer2;
      logic [7:0]           imgcal;
      logic [7:0]           invert_iq;
      logic [7:0]           lowbat;
      logic [7:0]           map1;
      logic [7:0]           map2;
      logic [7:0]           hop;
      logic [7:0]           refsel;
      logic [7:0]           pahi;
      logic [7:0]           frac;
      logic [1:0][39:0]     bank;
   } xcr_cfg_t;

   typedef struct packed {
      xcr_phase_t                      phase;
      logic [31:0]                     prdata;
      logic                            pslverr;
      xcr_cfg_t                        cfg;
      logic [19:0]                     rate_period;
      logic [FIFO_DEPTH-1:0][7:0]      mem;
      logic [FIFO_AW-1:0]              rd;
      logic [FIFO_AW-1:0]              wr;
      logic [FIFO_CW-1:0]              count;
      logic                            overrun;
      logic [7:0]                      modem_data;
      logic [7:0]                      cal_temp;
      logic [7:0]                      s1_flags1;
      logic [7:0]                      s2_flags1;
      logic                            s1_lowbat;
      logic                            s2_lowbat;
      logic                            lowbat_prev;
      logic [7:0]                      s1_temp;
      logic [7:0]                      s2_temp;
      logic [IRQ_W-1:0]                irq_status;
      logic [IRQ_W-1:0]                irq_enable;
      logic                            irq;
   } xcr_state_t;

endpackage

// [design/xcr_regs.sv]
// APB register bank, data FIFO and event logic of the transceiver configuration block
//
// Summary of operation
// - Family bit 7 of op-mode written only in sleep; otherwise write ignored.
// - Modulation field bits 6-5: 00 FSK, 01 OOK, others reserved.
// - Op-mode bit 3 picks high or low test bank from 0x61; resets to 1.
// - Mode bits 2-0: sleep, standby, synth-tx, tx, synth-rx, rx; 110/111 reserved.
// - Sixteen-bit rate divisor: upper byte at 0x02, lower byte at 0x03.
// - Data rate is crystal over divisor plus fraction at 0x5D divided by 16.
// - Divisor bytes reset to 0x1A and 0x0B, giving 4.8 kb/s.
// - Deviation word: bits 5-0 of 0x04 and byte 0x05, reset 0x52.
// - Power-on reset reloads every register with its reset value.
// - Address decoding depends on modem family, e.g. 0x3B differs per family.
// - 0x40 maps digital pins 0 to 3; 0x41 pins 4, 5 and clock output.
// - Status 0x3E shows PLL lock, timeout, RSSI flags; resets to 0x80.
// - Status 0x3F shows FIFO flags and low battery; resets to 0x40.
// - 0x42 holds a read-only silicon revision code.
// - 0x5B holds temperature captured at the last IQ calibration.
module xcr_regs
   import xcr_pkg::*;
(
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output      logic [31:0]            prdata,
   output      logic                   pready,
   output      logic                   pslverr,
   // Interrupt
   output      logic                   irq,
   // Configuration to the radio
   output      xcr_cfg_t               cfg,
   output      logic [19:0]            rate_period,
   // Modem side of the data FIFO
   input  wire logic                   modem_push,
   input  wire logic [7:0]             modem_push_data,
   input  wire logic                   modem_pop,
   output      logic [7:0]             modem_pop_data,
   output      logic [FIFO_CW-1:0]     fifo_count,
   // Analog status pins
   input  wire logic [7:0]             radio_flags_in,
   input  wire logic                   low_battery_in,
   input  wire logic [7:0]             temperature_in
);

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic is_mapped(input logic [IDX_W-1:0] i, input logic lr);
      logic m;
      m = 1'b0;
      case (i)
         IDX_FIFO, IDX_OPMODE, IDX_RATE_HI, IDX_RATE_LO, IDX_DEV_HI, IDX_DEV_LO,
         IDX_TIMER1, IDX_TIMER2, IDX_IMGCAL, IDX_TEMP, IDX_LOWBAT, IDX_FLAGS2,
         IDX_MAP1, IDX_MAP2, IDX_VERSION, IDX_REFSEL, IDX_PAHI, IDX_CALTEMP,
         IDX_AGC_REF, IDX_AGC_TH1, IDX_AGC_TH2, IDX_AGC_TH3, IDX_PLL,
         IDX_IRQ_STAT, IDX_IRQ_CLR, IDX_IRQ_EN:
            m = 1'b1;
         // Not decoded in long-range family
         IDX_FLAGS1, IDX_HOP, IDX_FRAC:
            m = ~lr;
         default:
            m = 1'b0;
      endcase
      return m;
   endfunction

   function automatic logic [7:0] reg_read(input xcr_state_t s, input logic [IDX_W-1:0] i);
      logic [7:0] d;
      xcr_bank_t  b;
      logic       lr;
      b  = s.cfg.bank[s.cfg.opmode.low_band_bank_select];
      lr = s.cfg.opmode.modem_family_select;
      d  = RST_ZERO;
      case (i)
         IDX_FIFO:     d = s.mem[s.rd];
         IDX_OPMODE:   d = s.cfg.opmode;
         IDX_RATE_HI:  d = s.cfg.rate_hi;
         IDX_RATE_LO:  d = s.cfg.rate_lo;
         IDX_DEV_HI:   d = s.cfg.dev_hi;
         IDX_DEV_LO:   d = s.cfg.dev_lo;
         IDX_TIMER1:   d = s.cfg.timer1;
         IDX_TIMER2:   d = s.cfg.timer2;
         IDX_IMGCAL:   d = lr ? s.cfg.invert_iq : s.cfg.imgcal;
         IDX_TEMP:     d = s.s2_temp;
         IDX_LOWBAT:   d = s.cfg.lowbat;
         IDX_FLAGS1:   d = lr ? RST_ZERO : s.s2_flags1;
         IDX_FLAGS2:
         begin
            d[F2_FULL]    = (s.count == FIFO_FULL_CNT);
            d[F2_EMPTY]   = (s.count == '0);
            d[F2_LEVEL]   = (s.count >= FIFO_LEVEL_CNT);
            d[F2_OVERRUN] = s.overrun;
            d[F2_LOWBAT]  = s.s2_lowbat;
         end
         IDX_MAP1:     d = s.cfg.map1;
         IDX_MAP2:     d = s.cfg.map2;
         IDX_VERSION:  d = REVISION_CODE;
         IDX_HOP:      d = lr ? RST_ZERO : s.cfg.hop;
         IDX_REFSEL:   d = s.cfg.refsel;
         IDX_PAHI:     d = s.cfg.pahi;
         IDX_CALTEMP:  d = s.cal_temp;
         IDX_FRAC:     d = lr ? RST_ZERO : s.cfg.frac;
         IDX_AGC_REF:  d = b.ref_level;
         IDX_AGC_TH1:  d = b.thresh1;
         IDX_AGC_TH2:  d = b.thresh2;
         IDX_AGC_TH3:  d = b.thresh3;
         IDX_PLL:      d = b.pll_bw;
         IDX_IRQ_STAT: d = 8'(s.irq_status);
         IDX_IRQ_EN:   d = 8'(s.irq_enable);
         default:      d = RST_ZERO;
      endcase
      return d;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   xcr_state_t st;
   xcr_state_t next_st;

   logic [IDX_W-1:0] idx;
   logic             mapped;
   logic             done;
   logic             host_push;
   logic             host_pop;
   logic             push;
   logic             pop;
   logic             push_ok;
   logic             pop_ok;
   logic [7:0]       push_data;
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] clr;
   xcr_bank_t        wb;
   logic             bsel;
   logic             lr;

   assign idx    = paddr[ADDR_LSB +: IDX_W];
   assign lr     = st.cfg.opmode.modem_family_select;
   assign mapped = is_mapped(idx, lr);
   assign bsel   = st.cfg.opmode.low_band_bank_select;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      next_st   = st;
      ev        = '0;
      clr       = '0;
      wb        = st.cfg.bank[bsel];
      done      = psel & penable & (st.phase == XCR_PH_ANSWER);
      host_push = done & pwrite & (idx == IDX_FIFO);
      host_pop  = done & ~pwrite & (idx == IDX_FIFO);

      // Two-flop synchronisers for the analog status pins
      next_st.s1_flags1   = radio_flags_in;
      next_st.s2_flags1   = st.s1_flags1;
      next_st.s1_lowbat   = low_battery_in;
      next_st.s2_lowbat   = st.s1_lowbat;
      next_st.lowbat_prev = st.s2_lowbat;
      next_st.s1_temp     = temperature_in;
      next_st.s2_temp     = st.s1_temp;
      ev[EV_LOWBAT]       = st.s2_lowbat & ~st.lowbat_prev;

      // APB: read data is latched on the same edge that raises pready so it is a flop
      case (st.phase)
         XCR_PH_IDLE:
         begin
            next_st.pslverr = 1'b0;
            if (psel && penable)
            begin
               next_st.phase   = XCR_PH_ANSWER;
               next_st.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, reg_read(st, idx)};
               next_st.pslverr = ~mapped;
            end
         end
         XCR_PH_ANSWER:
         begin
            next_st.phase   = XCR_PH_IDLE;
            next_st.pslverr = 1'b0;
         end
         default:
            next_st.phase = XCR_PH_IDLE;
      endcase

      // Register writes commit on the edge that completes the transfer
      if (done && pwrite && !mapped)
         ev[EV_BAD_WRITE] = 1'b1;
      if (done && pwrite && mapped)
      begin
         case (idx)
            IDX_OPMODE:
            begin
               if (st.cfg.opmode.mode == XCR_SLEEP)
                  next_st.cfg.opmode.modem_family_select = pwdata[7];
               else if (pwdata[7] != lr)
                  ev[EV_FAMILY_REJ] = 1'b1;
               next_st.cfg.opmode.modulation_scheme    = xcr_mod_t'(pwdata[6:5]);
               next_st.cfg.opmode.low_band_bank_select = pwdata[3];
               next_st.cfg.opmode.mode                 = xcr_mode_t'(pwdata[2:0]);
            end
            IDX_RATE_HI: next_st.cfg.rate_hi = pwdata[7:0];
            IDX_RATE_LO: next_st.cfg.rate_lo = pwdata[7:0];
            IDX_DEV_HI:  next_st.cfg.dev_hi  = pwdata[7:0] & DEV_HI_MASK;
            IDX_DEV_LO:  next_st.cfg.dev_lo  = pwdata[7:0];
            IDX_TIMER1:  next_st.cfg.timer1  = pwdata[7:0];
            IDX_TIMER2:  next_st.cfg.timer2  = pwdata[7:0];
            IDX_IMGCAL:
            begin
               if (lr)
                  next_st.cfg.invert_iq = pwdata[7:0];
               else
               begin
                  next_st.cfg.imgcal = pwdata[7:0] & IMGCAL_MASK;
                  // Start trigger: snapshot the current sensor reading
                  if (pwdata[IMGCAL_START])
                     next_st.cal_temp = st.s2_temp;
               end
            end
            IDX_LOWBAT:  next_st.cfg.lowbat = pwdata[7:0];
            IDX_FLAGS2:
               if (pwdata[F2_OVERRUN])
                  next_st.overrun = 1'b0;
            IDX_MAP1:    next_st.cfg.map1   = pwdata[7:0];
            IDX_MAP2:    next_st.cfg.map2   = pwdata[7:0];
            IDX_HOP:     next_st.cfg.hop    = pwdata[7:0];
            IDX_REFSEL:  next_st.cfg.refsel = pwdata[7:0];
            IDX_PAHI:    next_st.cfg.pahi   = pwdata[7:0];
            IDX_FRAC:    next_st.cfg.frac   = pwdata[7:0];
            IDX_AGC_REF: wb.ref_level = pwdata[7:0];
            IDX_AGC_TH1: wb.thresh1   = pwdata[7:0];
            IDX_AGC_TH2: wb.thresh2   = pwdata[7:0];
            IDX_AGC_TH3: wb.thresh3   = pwdata[7:0];
            IDX_PLL:     wb.pll_bw    = pwdata[7:0];
            IDX_IRQ_CLR: clr = pwdata[IRQ_W-1:0];
            IDX_IRQ_EN:  next_st.irq_enable = pwdata[IRQ_W-1:0];
            default:     next_st.cfg = st.cfg;
         endcase
      end
      next_st.cfg.bank[bsel] = wb;

      // FIFO: the host wins a same-cycle clash, the modem request is lost
      push      = host_push | modem_push;
      pop       = host_pop | modem_pop;
      push_data = host_push ? pwdata[7:0] : modem_push_data;
      push_ok   = push & (st.count != FIFO_FULL_CNT);
      pop_ok    = pop & (st.count != '0);
      if ((push && !push_ok) || (host_push && modem_push))
      begin
         ev[EV_OVERRUN]  = 1'b1;
         next_st.overrun = 1'b1;
      end
      if ((pop && !pop_ok) || (host_pop && modem_pop))
         ev[EV_UNDERRUN] = 1'b1;
      if (push_ok)
      begin
         next_st.mem[st.wr] = push_data;
         next_st.wr         = FIFO_AW'(st.wr + 1'b1);
      end
      if (pop_ok)
      begin
         next_st.rd = FIFO_AW'(st.rd + 1'b1);
         if (!host_pop)
            next_st.modem_data = st.mem[st.rd];
      end
      next_st.count = FIFO_CW'(st.count + FIFO_CW'(push_ok) - FIFO_CW'(pop_ok));

      // Fixed-point divisor with four fraction bits for the rate generator
      next_st.rate_period = {st.cfg.rate_hi, st.cfg.rate_lo, st.cfg.frac[FRAC_W-1:0]};

      // Sticky events: a set in the clearing cycle survives
      next_st.irq_status = (st.irq_status & ~clr) | ev;
      next_st.irq        = |(next_st.irq_status & next_st.irq_enable);
   end

   // ------------------------------------------------------------
   // State register; reset loads every documented value
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st                  <= '0;
         st.cfg.opmode       <= RST_OPMODE;
         st.cfg.rate_hi      <= RST_RATE_HI;
         st.cfg.rate_lo      <= RST_RATE_LO;
         st.cfg.dev_hi       <= RST_DEV_HI;
         st.cfg.dev_lo       <= RST_DEV_LO;
         st.cfg.timer1       <= RST_TIMER1;
         st.cfg.timer2       <= RST_TIMER2;
         st.cfg.imgcal       <= RST_IMGCAL;
         st.cfg.invert_iq    <= RST_IMGCAL;
         st.cfg.lowbat       <= RST_LOWBAT;
         st.cfg.map1         <= RST_MAP;
         st.cfg.map2         <= RST_MAP;
         st.cfg.hop          <= RST_HOP;
         st.cfg.refsel       <= RST_REFSEL;
         st.cfg.pahi         <= RST_PAHI;
         st.cfg.frac         <= RST_FRAC;
         st.cfg.bank         <= {2{RST_AGC_REF, RST_AGC_TH1, RST_AGC_TH2, RST_AGC_TH3, RST_PLL}};
         st.rate_period      <= {RST_RATE_HI, RST_RATE_LO, RST_FRAC[FRAC_W-1:0]};
         st.s1_flags1        <= RST_FLAGS1;
         st.s2_flags1        <= RST_FLAGS1;
      end
      else
         st <= next_st;
   end

   // ------------------------------------------------------------
   // Outputs straight from the state register
   // ------------------------------------------------------------
   assign prdata         = st.prdata;
   assign pready         = st.phase;
   assign pslverr        = st.pslverr;
   assign irq            = st.irq;
   assign cfg            = st.cfg;
   assign rate_period    = st.rate_period;
   assign modem_pop_data = st.modem_data;
   assign fifo_count     = st.count;

endmodule

// [sim/xcr_regs_checker.sv]
// Assertion checker for the transceiver configuration register bank
module xcr_regs_checker
   import xcr_pkg::*;
(
   // Clock and reset
   input wire logic               pclk,
   input wire logic               presetn,
   // Bus
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   // Configuration and FIFO
   input wire xcr_cfg_t           cfg,
   input wire logic [19:0]        rate_period,
   input wire logic [FIFO_CW-1:0] fifo_count
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access; psel && penable && !pready; endsequence
   sequence s_done; pready ##1 !pready; endsequence
   a_one_wait: assert property (s_access |=> s_done)
      else $error("answer not after one wait");
   a_rate_follow: assert property (1 |=> rate_period ==
      {$past(cfg.rate_hi), $past(cfg.rate_lo), $past(cfg.frac[3:0])})
      else $error("rate word lags");
   a_family_lock: assert property (cfg.opmode.mode != XCR_SLEEP
      |=> $stable(cfg.opmode.modem_family_select)) else $error("family moved");
   a_rate_hold: assert property (!(pready && pwrite)
      |=> $stable(cfg.rate_hi) && $stable(cfg.rate_lo)) else $error("rate changed");
   a_dev_reserved: assert property (cfg.dev_hi[7:6] == 2'b00)
      else $error("deviation top bits set");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_read_upper: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_fifo_bound: assert property (fifo_count <= 7'h40)
      else $error("fifo count too large");
endmodule
bind xcr_regs xcr_regs_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .prdata, .pready, .pslverr, .cfg, .rate_period, .fifo_count);

// [sim/tb_xcr_regs.sv]
// Self-checking testbench of the transceiver configuration register bank
module tb_xcr_regs
   import xcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [6:0] i; logic [7:0] w, r, e;} xcr_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic modem_pop, low_battery_in;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [19:0] rate_period;
   logic [7:0] modem_pop_data;
   logic [FIFO_CW-1:0] fifo_count;
   xcr_cfg_t cfg;
   int err_count, checked, cyc;
   xcr_row_t rows [21] = '{'{7'h02,8'h55,8'h1A,8'h55}, '{7'h03,8'hAA,8'h0B,8'hAA},
      '{7'h04,8'hFF,8'h00,8'h3F}, '{7'h05,8'h11,8'h52,8'h11}, '{7'h39,8'h01,8'hF5,8'h01},
      '{7'h3A,8'h02,8'h20,8'h02}, '{7'h3D,8'h05,8'h02,8'h05}, '{7'h3E,8'h00,8'h80,8'h80},
      '{7'h3F,8'h00,8'h40,8'h40}, '{7'h40,8'h12,8'h00,8'h12}, '{7'h41,8'h34,8'h00,8'h34},
      '{7'h42,8'h00,8'h5A,8'h5A}, '{7'h44,8'h66,8'h2D,8'h66}, '{7'h4B,8'h19,8'h09,8'h19},
      '{7'h4D,8'h87,8'h84,8'h87}, '{7'h5D,8'h0F,8'h00,8'h0F}, '{7'h61,8'h21,8'h13,8'h21},
      '{7'h62,8'h22,8'h0E,8'h22}, '{7'h63,8'h23,8'h5B,8'h23}, '{7'h64,8'h24,8'hDB,8'h24},
      '{7'h70,8'h70,8'hD0,8'h70}};
   xcr_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irq, .cfg, .rate_period, .modem_push(1'b0),
      .modem_push_data(8'h00), .modem_pop, .modem_pop_data, .fifo_count,
      .radio_flags_in(8'h80), .low_battery_in, .temperature_in(8'h00));
   initial
   begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   // Holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [6:0] i, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= {23'h0, i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20)
         chk(32'h0, 32'h1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         stop_test();
      end
   end
   initial
   begin
      {presetn, psel, penable, pwrite, modem_pop, low_battery_in} = '0;
      paddr = '0;
      pwdata = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1;
      foreach (rows[k])
      begin
         apb(0, rows[k].i, 0);
         chk(rd, {24'h0, rows[k].r});
         apb(1, rows[k].i, rows[k].w);
         apb(0, rows[k].i, 0);
         chk(rd, {24'h0, rows[k].e});
      end
      chk(32'(rate_period), 32'h55AAF);
      $display("register table done");
      apb(1, IDX_IRQ_EN, 8'h1C);
      apb(1, 7'h7F, 8'h00);
      chk(32'(er), 32'h1);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h1);
      apb(1, IDX_IRQ_CLR, 8'h1F);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
      apb(1, IDX_OPMODE, 8'h81);
      apb(0, IDX_OPMODE, 0);
      chk(rd, 32'h01);
      apb(0, IDX_IRQ_STAT, 0);
      chk(rd, 32'h04);
      for (int m = 0; m < 8; m++)
      begin
         apb(1, IDX_OPMODE, {5'b00001, 3'(m)});
         apb(0, IDX_OPMODE, 0);
         chk(rd, 32'h08 | m);
      end
      apb(1, IDX_OPMODE, 8'h00);
      apb(1, IDX_OPMODE, 8'hA0);
      apb(0, IDX_OPMODE, 0);
      chk(rd, 32'hA0);
      apb(0, IDX_FLAGS1, 0);
      chk(32'(er), 32'h1);
      apb(1, IDX_OPMODE, 8'h09);
      $display("mode tests done");
      apb(1, IDX_IRQ_CLR, 8'h1F);
      low_battery_in <= 1;
      repeat (5) @(posedge pclk);
      apb(0, IDX_IRQ_STAT, 0);
      chk(32'(rd[4]), 32'h1);
      apb(1, IDX_FIFO, 8'hA5);
      // Count settles only after the completing edge
      @(posedge pclk);
      chk(32'(fifo_count), 32'h1);
      modem_pop <= 1;
      @(posedge pclk);
      modem_pop <= 0;
      @(posedge pclk);
      chk(32'(modem_pop_data), 32'hA5);
      $display("event and fifo tests done");
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(0, IDX_RATE_HI, 0);
      chk(rd, 32'h1A);
      apb(0, IDX_OPMODE, 0);
      chk(rd, 32'h09);
      chk(32'(rate_period), 32'h1A0B0);
      $display("reset test done");
      stop_test();
   end
endmodule
